// ---- common/phy_link_status_regs.vh ----
// register offsets, field positions, reset values and timing for the status bank
`ifndef PHY_LINK_STATUS_REGS_VH
`define PHY_LINK_STATUS_REGS_VH
`define REG_IDX_LINK_STATUS   8'h11
`define REG_IDX_CTRL_TWO      8'h14
`define REG_IDX_RX_ERR        8'h15
`define REG_IDX_SOFT_RESET    8'h30
`define FLD_SPEED_HI          15
`define FLD_SPEED_LO          14
`define FLD_DUPLEX            13
`define FLD_PAGE_RX           12
`define FLD_RESOLVED          11
`define FLD_LINK              10
`define FLD_CABLE_HI          9
`define FLD_CABLE_LO          7
`define FLD_XOVER             6
`define FLD_TX_PAUSE          3
`define FLD_RX_PAUSE          2
`define FLD_POLARITY          1
`define FLD_JABBER            0
`define FLD_IDLE_LOSS         15
`define FLD_RSVD_HI           14
`define FLD_RSVD_LO           4
`define FLD_ANEG_EN           3
`define FLD_SOFT_RESET        0
`define CTRL_TWO_RESET        16'h0C68
`define SPEED_GIG             2'h2
`define IDLE_TIMEOUT_US       1000
`define CLK_MHZ               250
`define IDLE_TIMEOUT_CYC      (`IDLE_TIMEOUT_US * `CLK_MHZ)
`endif

// ---- hdl/phy_link_status_and_error_regs.v ----
// apb register bank for phy link status, control and receive errors
`timescale 1ns/100ps
`include "phy_link_status_regs.vh"
module phy_link_status_and_error_regs #(
  parameter [31:0] IDLE_TIMEOUT_CYC = `IDLE_TIMEOUT_CYC
) (
  input  wire        clk_sys_i,
  input  wire        arst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [9:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        aneg_done_i,
  input  wire        page_rx_i,
  input  wire        link_up_i,
  input  wire [1:0]  speed_i,
  input  wire        duplex_full_i,
  input  wire [2:0]  cable_len_i,
  input  wire        pair_ab_swap_i,
  input  wire        pair_cd_swap_i,
  input  wire        mac_tx_pause_i,
  input  wire        mac_rx_pause_i,
  input  wire [3:0]  pair_reversed_i,
  input  wire        jabber_i,
  input  wire        idle_seen_i,
  input  wire        rx_error_i,
  output wire        link_up_o,
  output wire        basex_aneg_en_o
);

  // reset image of the stored control bits
  localparam [15:0] CTRL_RST = `CTRL_TWO_RESET;

  // number of twisted pairs watched for reversed wires
  localparam integer PAIRS = 4;

  // stored control bits; bit 15 is a live flag, not stored
  reg  [14:0] ctrl_r;
  // enable actually in force, only refreshed by a soft reset
  reg         aneg_act_r;

  // latch-high page flag
  reg         page_lh_r;

  // idle watchdog state
  reg         idle_loss_r;
  reg  [31:0] idle_cnt_r;

  // saturating receive error counter
  reg  [15:0] err_cnt_r;

  // bus phase decode
  wire        setup_w;
  wire        acc_w;
  wire        rd_w;
  wire        wr_w;
  wire [7:0]  idx_w;
  wire        hit_w;

  // per-register selects
  wire        sel_status_w;
  wire        sel_ctrl_w;
  wire        sel_err_w;
  wire        sel_srst_w;

  // per-register strobes, all qualified by the access phase
  wire        rd_status_w;
  wire        rd_err_w;
  wire        wr_ctrl_w;
  wire        wr_srst_w;

  // status field sources
  wire        resolved_w;
  wire [1:0]  speed_w;
  wire        duplex_w;
  wire        xover_w;
  wire        tx_pause_w;
  wire        rx_pause_w;
  wire [3:0]  pair_flip_w;
  wire        polarity_w;
  wire [15:0] status_w;
  wire [15:0] ctrl_view_w;

  // idle watchdog helpers
  wire        quiet_w;
  wire        idle_expired_w;

  // error counter helpers
  wire        err_full_w;
  wire [15:0] err_inc_w;

  // read word selected from the index
  reg  [31:0] rdata_nxt;

  // index compare, shared by every select below
  function idx_is;
    input [7:0] idx;
    input [7:0] want;
    begin
      idx_is = (idx == want);
    end
  endfunction

  // only these four words answer without an error
  function is_mapped;
    input [7:0] idx;
    begin
      is_mapped = idx_is(idx, `REG_IDX_LINK_STATUS) |
                  idx_is(idx, `REG_IDX_CTRL_TWO) |
                  idx_is(idx, `REG_IDX_RX_ERR) |
                  idx_is(idx, `REG_IDX_SOFT_RESET);
    end
  endfunction

  // zero-wait slave: ready as soon as the access phase opens
  assign setup_w   = psel_i & ~penable_i;
  assign acc_w     = psel_i & penable_i;
  assign rd_w      = acc_w & ~pwrite_i;
  assign wr_w      = acc_w & pwrite_i;
  assign idx_w     = paddr_i[9:2];
  assign hit_w     = is_mapped(idx_w);
  assign pready_o  = 1'h1;
  assign pslverr_o = acc_w & ~hit_w;

  // decoded selects; low address bits ignored, words are aligned
  assign sel_status_w = idx_is(idx_w, `REG_IDX_LINK_STATUS);
  assign sel_ctrl_w   = idx_is(idx_w, `REG_IDX_CTRL_TWO);
  assign sel_err_w    = idx_is(idx_w, `REG_IDX_RX_ERR);
  assign sel_srst_w   = idx_is(idx_w, `REG_IDX_SOFT_RESET);

  // side effects only at the access edge, never in setup
  assign rd_status_w = rd_w & sel_status_w;
  assign rd_err_w    = rd_w & sel_err_w;
  assign wr_ctrl_w   = wr_w & sel_ctrl_w;
  assign wr_srst_w   = wr_w & sel_srst_w & pwdata_i[`FLD_SOFT_RESET];

  // resolved while aneg finished or the active setting says disabled
  assign resolved_w = aneg_done_i | ~aneg_act_r;

  // qualified fields read zero until resolution, not stale values
  assign speed_w    = resolved_w ? speed_i : 2'h0;
  assign duplex_w   = resolved_w & duplex_full_i;
  assign xover_w    = resolved_w & pair_ab_swap_i & pair_cd_swap_i;
  assign tx_pause_w = resolved_w & mac_tx_pause_i;
  assign rx_pause_w = resolved_w & mac_rx_pause_i;

  // one reversal flag per twisted pair
  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp = gp + 1) begin : g_pair
      assign pair_flip_w[gp] = pair_reversed_i[gp];
    end
  endgenerate

  // any single reversed pair is enough
  assign polarity_w = |pair_flip_w;

  // speed and duplex fields
  assign status_w[`FLD_SPEED_HI:`FLD_SPEED_LO] = speed_w;
  assign status_w[`FLD_DUPLEX]                 = duplex_w;

  // negotiation progress fields
  assign status_w[`FLD_PAGE_RX]  = page_lh_r;
  assign status_w[`FLD_RESOLVED] = resolved_w;

  // link as forced by the watchdog, so software sees the real state
  assign status_w[`FLD_LINK] = link_up_o;

  // cable class passed through unqualified
  assign status_w[`FLD_CABLE_HI:`FLD_CABLE_LO] = cable_len_i;

  // pair layout and unused bits
  assign status_w[`FLD_XOVER] = xover_w;
  assign status_w[5:4]        = 2'h0;

  // mirrored host mac pause capability
  assign status_w[`FLD_TX_PAUSE] = tx_pause_w;
  assign status_w[`FLD_RX_PAUSE] = rx_pause_w;

  // line fault fields, live views
  assign status_w[`FLD_POLARITY] = polarity_w;
  assign status_w[`FLD_JABBER]   = jabber_i;

  // bit 15 is the live idle-loss flag, never a stored bit
  assign ctrl_view_w = {idle_loss_r, ctrl_r};

  // idle loss forces the link down regardless of the line
  assign link_up_o       = link_up_i & ~idle_loss_r;
  assign basex_aneg_en_o = aneg_act_r;

  // control register; reserved bits are stored as written
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= CTRL_RST[`FLD_RSVD_HI:0];
    end else if (wr_ctrl_w) begin
      ctrl_r <= pwdata_i[`FLD_RSVD_HI:0];
    end
  end

  // new enable only applied on soft reset, so a half-written
  // configuration never restarts negotiation
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aneg_act_r <= CTRL_RST[`FLD_ANEG_EN];
    end else if (wr_srst_w) begin
      aneg_act_r <= ctrl_r[`FLD_ANEG_EN];
    end
  end

  // latch-high page flag; a new page beats the read clear
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_lh_r <= 1'h0;
    end else if (page_rx_i) begin
      page_lh_r <= 1'h1;
    end else if (rd_status_w) begin
      page_lh_r <= 1'h0;
    end
  end

  // a cycle with link reported and no idle pattern
  assign quiet_w        = link_up_i & ~idle_seen_i;
  assign idle_expired_w = (idle_cnt_r >= IDLE_TIMEOUT_CYC - 32'h1);

  // idle watchdog, only armed while the line reports link;
  // the count stops at the limit so it cannot wrap
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt_r  <= 32'h0;
      idle_loss_r <= 1'h0;
    end else if (!quiet_w) begin
      idle_cnt_r  <= 32'h0;
      idle_loss_r <= 1'h0;
    end else if (idle_expired_w) begin
      idle_loss_r <= 1'h1;
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  // counter helpers
  assign err_full_w = &err_cnt_r;
  assign err_inc_w  = err_cnt_r + 16'h0001;

  // error counter: an error on the clearing read counts as one,
  // but an error in the setup cycle of the read is neither returned nor kept
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_cnt_r <= 16'h0000;
    end else if (rd_err_w) begin
      err_cnt_r <= {15'h0, rx_error_i};
    end else if (rx_error_i && !err_full_w) begin
      err_cnt_r <= err_inc_w;
    end
  end

  // read word from the index; unmapped words read zero
  always @* begin
    rdata_nxt = 32'h0;
    case (idx_w)
      `REG_IDX_LINK_STATUS: rdata_nxt = {16'h0, status_w};
      `REG_IDX_CTRL_TWO:    rdata_nxt = {16'h0, ctrl_view_w};
      `REG_IDX_RX_ERR:      rdata_nxt = {16'h0, err_cnt_r};
      default:              rdata_nxt = 32'h0;
    endcase
  end

  // read data captured in setup so it stands through the access
  // phase; the value is a snapshot one cycle before the clear
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0;
    end else if (setup_w && !pwrite_i) begin
      prdata_o <= rdata_nxt;
    end
  end

endmodule

// ---- test/phy_regs_sva.sv ----
// assertion checker for the phy status register bank
`timescale 1ns/100ps
module phy_regs_sva #(
  parameter [31:0] IDLE_TIMEOUT_CYC = 20
) (
  input wire        clk_sys_i,
  input wire        arst_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [9:0]  paddr_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        aneg_done_i,
  input wire        link_up_i,
  input wire        jabber_i,
  input wire        idle_seen_i,
  input wire        link_up_o,
  input wire        basex_aneg_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // access decode; the soft reset word counts as mapped
  wire acc = psel_i && penable_i;
  wire st = psel_i && !penable_i && !pwrite_i && paddr_i == 10'h044;
  wire map = paddr_i == 10'h044 || paddr_i == 10'h050 ||
    paddr_i == 10'h054 || paddr_i == 10'h0C0;
  reg [31:0] quiet_r;
  // cycles with link up and no idle, mirrors the watchdog
  always @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i) quiet_r <= 32'h0;
    else quiet_r <= (link_up_i && !idle_seen_i) ? quiet_r + 32'h1 : 32'h0;
  AST_READY: assert property (pready_o) else $error("pready low");
  AST_UNMAP: assert property (acc && !map |-> pslverr_o) else $error("unmap");
  AST_MAP: assert property (acc && map |-> !pslverr_o) else $error("map err");
  AST_LINK_DOWN:
    assert property (!link_up_i |-> !link_up_o) else $error("link out up");
  AST_IDLE_LOSS:
    assert property (quiet_r > IDLE_TIMEOUT_CYC + 1 |-> !link_up_o)
    else $error("no idle loss");
  AST_UPPER:
    assert property (acc && !pwrite_i |-> prdata_o[31:16] == 16'h0)
    else $error("upper bits set");
  AST_RESOLVED:
    assert property (st |=> prdata_o[11] ==
      $past(aneg_done_i || !basex_aneg_en_o)) else $error("resolved");
  AST_JABBER:
    assert property (st |=> prdata_o[0] == $past(jabber_i)) else $error("jab");
  cover property (acc && !map);
  cover property (quiet_r > IDLE_TIMEOUT_CYC + 1);
  cover property (st && !basex_aneg_en_o);
endmodule
bind phy_link_status_and_error_regs phy_regs_sva
  #(.IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC)) u_sva (.*);

// ---- test/mac_partner.sv ----
// host mac model: pause capability and idle stream
`timescale 1ns/100ps
module mac_partner (
  input  wire       clk_i,
  input  wire       idles_on_i,
  input  wire [1:0] pause_i,
  output reg        idle_o,
  output wire       tx_pause_o,
  output wire       rx_pause_o
);
  assign {tx_pause_o, rx_pause_o} = pause_i;
  initial idle_o = 1'h0;
  // idles on every other cycle, the sparse case for the watchdog
  always @(posedge clk_i)
    idle_o <= idles_on_i & ~idle_o;
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the phy status register bank
`timescale 1ns/100ps
`include "phy_link_status_regs.vh"
module testbench;
  reg        clk_sys_i, arst_n_i, psel_i, penable_i, pwrite_i, serr;
  reg        aneg_done_i, page_rx_i, link_up_i, duplex_full_i, jabber_i;
  reg        pair_ab_swap_i, pair_cd_swap_i, rx_error_i, idles_on;
  reg [1:0]  speed_i, pause;
  reg [2:0]  cable_len_i;
  reg [3:0]  pair_reversed_i;
  reg [9:0]  paddr_i;
  reg [31:0] pwdata_i, rdat;
  wire [31:0] prdata_o;
  wire       pready_o, pslverr_o, link_up_o, basex_aneg_en_o;
  wire       idle_seen_i, mac_tx_pause_i, mac_rx_pause_i;
  integer    errors = 0, checks = 0;
  phy_link_status_and_error_regs #(.IDLE_TIMEOUT_CYC(20)) dut (.*);
  mac_partner mac (.clk_i(clk_sys_i), .idles_on_i(idles_on), .pause_i(pause),
    .idle_o(idle_seen_i), .tx_pause_o(mac_tx_pause_i),
    .rx_pause_o(mac_rx_pause_i));
  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task chk(input string nm, input [31:0] g, input [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task apb(input [7:0] idx, input wr, input [31:0] wd);
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i} <= {2'h2, wr};
    paddr_i <= {idx, 2'h0};
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'h1)
      @(posedge clk_sys_i);
    rdat = prdata_o;
    serr = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  task rd(input [7:0] idx, input [31:0] e);
    apb(idx, 1'h0, 32'h0);
    chk("prdata", rdat, e);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #350000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {aneg_done_i, page_rx_i, link_up_i, duplex_full_i, jabber_i} = '0;
    {pair_ab_swap_i, pair_cd_swap_i, rx_error_i, idles_on} = '0;
    {speed_i, pause, cable_len_i, pair_reversed_i} = '0;
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    rd(`REG_IDX_CTRL_TWO, 32'h0C68);
    rd(`REG_IDX_LINK_STATUS, 32'h0);
    rd(`REG_IDX_RX_ERR, 32'h0);
    {aneg_done_i, speed_i, duplex_full_i, cable_len_i} <= 7'h6C;
    {pair_ab_swap_i, pair_cd_swap_i, pause, pair_reversed_i} <= 8'hF8;
    {jabber_i, link_up_i, idles_on, page_rx_i} <= 4'hF;
    @(posedge clk_sys_i);
    page_rx_i <= 1'h0;
    rd(`REG_IDX_LINK_STATUS, 32'hBE4F);
    rd(`REG_IDX_LINK_STATUS, 32'hAE4F);
    rx_error_i <= 1'h1;
    repeat (5) @(posedge clk_sys_i);
    rx_error_i <= 1'h0;
    rd(`REG_IDX_RX_ERR, 32'h5);
    rd(`REG_IDX_RX_ERR, 32'h0);
    rx_error_i <= 1'h1;
    repeat (65540) @(posedge clk_sys_i);
    rx_error_i <= 1'h0;
    rd(`REG_IDX_RX_ERR, 32'hFFFF);
    idles_on <= 1'h0;
    repeat (40) @(posedge clk_sys_i);
    chk("link", link_up_o, 32'h0);
    rd(`REG_IDX_CTRL_TWO, 32'h8C68);
    idles_on <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    chk("link", link_up_o, 32'h1);
    rd(`REG_IDX_CTRL_TWO, 32'h0C68);
    apb(`REG_IDX_CTRL_TWO, 1'h1, rdat & ~32'h8);
    rd(`REG_IDX_CTRL_TWO, 32'h0C60);
    chk("aneg", basex_aneg_en_o, 32'h1);
    apb(`REG_IDX_SOFT_RESET, 1'h1, 32'h1);
    aneg_done_i <= 1'h0;
    rd(`REG_IDX_LINK_STATUS, 32'hAE4F);
    chk("aneg", basex_aneg_en_o, 32'h0);
    apb(8'h12, 1'h0, 32'h0);
    chk("slverr", serr, 32'h1);
    chk("unmapped", rdat, 32'h0);
    give_verdict;
  end
endmodule
